/* uabd_pkg.sv */
// package: register map, fields, reset values and prescale counts for auto-baud detect
package uabd_pkg;
  // register byte offsets (apb, one aligned word each)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DIV = 8'h08;
  localparam logic [7:0] OFS_RXHOLD = 8'h0c;
  localparam logic [7:0] OFS_TXHOLD = 8'h10;
  // control field positions
  localparam int CTRL_ARM = 0;
  localparam int CTRL_WAKE = 1;
  localparam int CTRL_WIDE = 2;
  localparam int CTRL_HIGH = 3;
  localparam int CTRL_SYNC = 4;
  // status field positions
  localparam int STAT_OVF = 0;
  localparam int STAT_RXF = 1;
  localparam int STAT_BUSY = 2;
  localparam int STAT_TXBUSY = 3;
  // reset values
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [15:0] DIV_RST = 16'h0000;
  // counter clock divides of the oscillator (rate-select pairs 00,01,10,11)
  localparam logic [9:0] DIV_00 = 10'h200;
  localparam logic [9:0] DIV_01 = 10'h080;
  localparam logic [9:0] DIV_10 = 10'h080;
  localparam logic [9:0] DIV_11 = 10'h020;
  // number of rising edges that close a measurement
  localparam logic [2:0] EDGE_LAST = 3'h5;
  // transmit busy time in clocks after a holding write
  localparam logic [7:0] TX_BUSY_CLKS = 8'ha0;
  typedef enum logic [2:0] {
    UABD_IDLE,
    UABD_BREAK,
    UABD_WAIT_START,
    UABD_WAIT_RISE,
    UABD_MEASURE
  } uabd_state_e;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } uabd_apb_req_s;
endpackage

/* uabd_prescale.sv */
// prescaler: one-cycle tick every n enabled clocks, restartable
`timescale 1ns/100ps
module uabd_prescale
(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_restart,
  input wire logic [9:0] i_div,
  output logic o_tick
);
  logic [9:0] cnt_r;
  logic [9:0] cnt_nxt;
  logic tick_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (i_restart)
    begin
      cnt_nxt = 10'h000;
    end
    else if (cnt_r >= i_div - 10'h001)
    begin
      cnt_nxt = 10'h000;
      tick_nxt = 1'b1;
    end
    else
    begin
      cnt_nxt = cnt_r + 10'h001;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      cnt_r <= 10'h000;
      o_tick <= 1'b0;
    end
    else if (i_ce)
    begin
      cnt_r <= cnt_nxt;
      o_tick <= tick_nxt;
    end
  end
endmodule

/* uabd_top.sv */
// auto-baud detect for the serial port: apb registers, edge timing, divisor capture
// How it works
// - detection runs only in async mode with wake-on-edge clear, or after a break
// - a start bit on the receive line while armed begins measuring
// - arming clears the baud counter, then a start bit is awaited
// - counting starts at the first rise; the fifth rise leaves the value in the divider
// - the arm bit clears by itself at the fifth rising edge
// - counter rollover from ffff to 0000 sets the overflow flag
// - overflow flag set by hardware, software may also set or clear it
// - after rollover the measurement goes on and arm stays set
// - the counter ticks at one eighth of the normal counter clock
// - counter clock is osc over 512, 128, 128, 32 by rate pair
// - low and high divider always count together as 16 bits
// - the receive state machine is held idle while detecting
// - receive flag sets at the fifth rise; reading receive holding clears it
// - with wake-on-edge also set, the byte after the break is measured
// - transmit holding writes are refused while armed
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/100ps
module uabd_top
(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_rx,
  output logic o_rx_hold_idle,
  output logic [15:0] o_baud_div,
  output logic o_tx_load
);
  uabd_pkg::uabd_apb_req_s req;
  uabd_pkg::uabd_state_e state_r;
  uabd_pkg::uabd_state_e state_nxt;
  logic [4:0] ctrl_r;
  logic [4:0] ctrl_nxt;
  logic ovf_r;
  logic ovf_nxt;
  logic rxf_r;
  logic rxf_nxt;
  logic [15:0] div_r;
  logic [15:0] div_nxt;
  logic [2:0] edges_r;
  logic [2:0] edges_nxt;
  logic [2:0] sub_r;
  logic [2:0] sub_nxt;
  logic rx_d_r;
  logic [7:0] tx_busy_r;
  logic [7:0] tx_busy_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt;
  logic pslverr_nxt;
  logic tx_load_nxt;
  logic [7:0] txd_r;
  logic [7:0] txd_nxt;
  logic [9:0] pre_div;
  logic tick;
  logic restart;
  logic wr_acc;
  logic rd_acc;
  logic rise;
  logic fall;
  logic mapped;
  logic active;

  assign req = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite,
                 paddr: i_paddr, pwdata: i_pwdata};
  // single-wait-state slave: access phase completes when o_pready is high
  assign wr_acc = req.psel && req.penable && req.pwrite && o_pready;
  assign rd_acc = req.psel && req.penable && !req.pwrite && o_pready;
  assign mapped = (req.paddr == uabd_pkg::OFS_CTRL) || (req.paddr == uabd_pkg::OFS_STATUS)
    || (req.paddr == uabd_pkg::OFS_DIV) || (req.paddr == uabd_pkg::OFS_RXHOLD)
    || (req.paddr == uabd_pkg::OFS_TXHOLD);
  assign rise = i_rx && !rx_d_r;
  assign fall = !i_rx && rx_d_r;
  assign active = (state_r != uabd_pkg::UABD_IDLE);

  // counter clock select by rate pair
  always_comb
  begin
    unique case ({ctrl_r[uabd_pkg::CTRL_WIDE], ctrl_r[uabd_pkg::CTRL_HIGH]})
      2'b00: pre_div = uabd_pkg::DIV_00;
      2'b01: pre_div = uabd_pkg::DIV_01;
      2'b10: pre_div = uabd_pkg::DIV_10;
      2'b11: pre_div = uabd_pkg::DIV_11;
    endcase
  end

  assign restart = (state_r != uabd_pkg::UABD_MEASURE);

  uabd_prescale u_pre
  (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_restart(restart),
    .i_div(pre_div),
    .o_tick(tick)
  );

  // measurement state, divider, flags, control
  always_comb
  begin
    state_nxt = state_r;
    ctrl_nxt = ctrl_r;
    ovf_nxt = ovf_r;
    rxf_nxt = rxf_r;
    div_nxt = div_r;
    edges_nxt = edges_r;
    sub_nxt = sub_r;
    tx_busy_nxt = (tx_busy_r != 8'h00) ? tx_busy_r - 8'h01 : 8'h00;
    tx_load_nxt = 1'b0;
    txd_nxt = txd_r;
    // software register writes
    if (wr_acc && req.paddr == uabd_pkg::OFS_CTRL)
    begin
      ctrl_nxt = req.pwdata[4:0];
    end
    if (wr_acc && req.paddr == uabd_pkg::OFS_STATUS)
    begin
      ovf_nxt = req.pwdata[uabd_pkg::STAT_OVF];
    end
    // preload allowed until counting starts, locked while measuring
    if (wr_acc && req.paddr == uabd_pkg::OFS_DIV && state_r != uabd_pkg::UABD_MEASURE)
    begin
      div_nxt = req.pwdata[15:0];
    end
    if (wr_acc && req.paddr == uabd_pkg::OFS_TXHOLD && !ctrl_r[uabd_pkg::CTRL_ARM])
    begin
      txd_nxt = req.pwdata[7:0];
      tx_load_nxt = 1'b1;
      tx_busy_nxt = uabd_pkg::TX_BUSY_CLKS;
    end
    if (rd_acc && req.paddr == uabd_pkg::OFS_RXHOLD)
    begin
      rxf_nxt = 1'b0;
    end
    unique case (state_r)
      uabd_pkg::UABD_IDLE:
      begin
        if (ctrl_r[uabd_pkg::CTRL_ARM] && !ctrl_r[uabd_pkg::CTRL_SYNC])
        begin
          div_nxt = 16'h0000;
          edges_nxt = 3'h0;
          sub_nxt = 3'h0;
          state_nxt = ctrl_r[uabd_pkg::CTRL_WAKE] ? uabd_pkg::UABD_BREAK
            : uabd_pkg::UABD_WAIT_START;
        end
      end
      uabd_pkg::UABD_BREAK:
      begin
        if (rise)
        begin
          state_nxt = uabd_pkg::UABD_WAIT_START;
        end
      end
      uabd_pkg::UABD_WAIT_START:
      begin
        if (fall)
        begin
          state_nxt = uabd_pkg::UABD_WAIT_RISE;
        end
      end
      uabd_pkg::UABD_WAIT_RISE:
      begin
        if (rise)
        begin
          edges_nxt = 3'h1;
          state_nxt = uabd_pkg::UABD_MEASURE;
        end
      end
      uabd_pkg::UABD_MEASURE:
      begin
        if (tick)
        begin
          sub_nxt = sub_r + 3'h1;
          if (sub_r == 3'h7)
          begin
            div_nxt = div_r + 16'h0001;
            if (div_r == 16'hffff)
            begin
              ovf_nxt = 1'b1;
            end
          end
        end
        if (rise)
        begin
          edges_nxt = edges_r + 3'h1;
          if (edges_r + 3'h1 == uabd_pkg::EDGE_LAST)
          begin
            ctrl_nxt[uabd_pkg::CTRL_ARM] = 1'b0;
            rxf_nxt = 1'b1;
            state_nxt = uabd_pkg::UABD_IDLE;
          end
        end
      end
    endcase
    // software disarm abandons a measurement, divider keeps its count
    if (active && !ctrl_nxt[uabd_pkg::CTRL_ARM])
    begin
      state_nxt = uabd_pkg::UABD_IDLE;
    end
  end

  // apb read path and answer
  always_comb
  begin
    prdata_nxt = 32'h0000_0000;
    pready_nxt = req.psel && req.penable && !o_pready;
    pslverr_nxt = pready_nxt && !mapped;
    if (req.psel && !req.pwrite)
    begin
      unique case (req.paddr)
        uabd_pkg::OFS_CTRL: prdata_nxt = {27'h0, ctrl_r};
        uabd_pkg::OFS_STATUS: prdata_nxt = {28'h0, tx_busy_r != 8'h00, active, rxf_r, ovf_r};
        uabd_pkg::OFS_DIV: prdata_nxt = {16'h0, div_r};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      state_r <= uabd_pkg::UABD_IDLE;
      ctrl_r <= uabd_pkg::CTRL_RST;
      ovf_r <= 1'b0;
      rxf_r <= 1'b0;
      div_r <= uabd_pkg::DIV_RST;
      edges_r <= 3'h0;
      sub_r <= 3'h0;
      rx_d_r <= 1'b1;
      tx_busy_r <= 8'h00;
      txd_r <= 8'h00;
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_rx_hold_idle <= 1'b0;
      o_baud_div <= uabd_pkg::DIV_RST;
      o_tx_load <= 1'b0;
    end
    else if (i_ce)
    begin
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      ovf_r <= ovf_nxt;
      rxf_r <= rxf_nxt;
      div_r <= div_nxt;
      edges_r <= edges_nxt;
      sub_r <= sub_nxt;
      rx_d_r <= i_rx;
      tx_busy_r <= tx_busy_nxt;
      txd_r <= txd_nxt;
      o_prdata <= prdata_nxt;
      o_pready <= pready_nxt;
      o_pslverr <= pslverr_nxt;
      o_rx_hold_idle <= (state_nxt != uabd_pkg::UABD_IDLE);
      o_baud_div <= div_nxt;
      o_tx_load <= tx_load_nxt;
    end
  end

  // checks
  chk_tx_refused: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_ce && wr_acc && req.paddr == uabd_pkg::OFS_TXHOLD && ctrl_r[uabd_pkg::CTRL_ARM])
    |=> !o_tx_load)
    else $error("transmit write accepted while armed");
  chk_arm_clear: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_ce && state_r == uabd_pkg::UABD_MEASURE && rise && edges_r == 3'h4)
    |=> !ctrl_r[uabd_pkg::CTRL_ARM] && rxf_r && state_r == uabd_pkg::UABD_IDLE)
    else $error("fifth edge did not close measurement");
  chk_arm_zero: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_ce && state_r == uabd_pkg::UABD_IDLE && state_nxt == uabd_pkg::UABD_WAIT_START)
    |=> div_r == 16'h0000)
    else $error("counter not cleared on arm");
  chk_ovf_set: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_ce && state_r == uabd_pkg::UABD_MEASURE && tick && sub_r == 3'h7 && div_r == 16'hffff)
    |=> ovf_r && div_r == 16'h0000)
    else $error("rollover missed");
  chk_ovf_keep: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_ce && state_r == uabd_pkg::UABD_MEASURE && div_r == 16'hffff && tick && !rise
     && sub_r == 3'h7 && !wr_acc)
    |=> ctrl_r[uabd_pkg::CTRL_ARM] && state_r == uabd_pkg::UABD_MEASURE)
    else $error("rollover ended detection");
  chk_idle_hold: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_ce |=> (o_rx_hold_idle == (state_r != uabd_pkg::UABD_IDLE)))
    else $error("receive not held idle");
  chk_sync_block: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (state_r == uabd_pkg::UABD_IDLE && ctrl_r[uabd_pkg::CTRL_SYNC])
    |=> state_r == uabd_pkg::UABD_IDLE)
    else $error("detection started in sync mode");
  chk_rxf_clear: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_ce && rd_acc && req.paddr == uabd_pkg::OFS_RXHOLD
     && !(state_r == uabd_pkg::UABD_MEASURE && rise && edges_r == 3'h4))
    |=> !rxf_r)
    else $error("receive flag not cleared by read");
  chk_idle_meas: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_ce && active && !wr_acc
     && !(state_r == uabd_pkg::UABD_MEASURE && rise && edges_r == 3'h4))
    |=> o_rx_hold_idle)
    else $error("receive not held idle while detecting");
  chk_pready_pulse: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_ce && o_pready)
    |=> !o_pready)
    else $error("bus answer longer than one cycle");
  chk_start_bit: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_ce && state_r == uabd_pkg::UABD_WAIT_START && fall && !wr_acc)
    |=> state_r == uabd_pkg::UABD_WAIT_RISE)
    else $error("start bit not taken");
  chk_first_rise: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_ce && state_r == uabd_pkg::UABD_WAIT_RISE && rise && !wr_acc)
    |=> state_r == uabd_pkg::UABD_MEASURE && edges_r == 3'h1)
    else $error("counting did not start at first rise");
  chk_break_wait: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_ce && state_r == uabd_pkg::UABD_BREAK && !rise && !wr_acc)
    |=> state_r == uabd_pkg::UABD_BREAK)
    else $error("break left before its end");
  chk_eighth_tick: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_ce && state_r == uabd_pkg::UABD_MEASURE && tick && sub_r != 3'h7)
    |=> $stable(div_r))
    else $error("counter stepped before eighth tick");
  chk_count_step: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_ce && state_r == uabd_pkg::UABD_MEASURE && tick && sub_r == 3'h7)
    |=> div_r == $past(div_r) + 16'h0001)
    else $error("counter did not step as one 16-bit value");
  chk_div_keep: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_ce && state_r == uabd_pkg::UABD_IDLE && !wr_acc
     && !(ctrl_r[uabd_pkg::CTRL_ARM] && !ctrl_r[uabd_pkg::CTRL_SYNC]))
    |=> $stable(div_r))
    else $error("divider lost its value while idle");
  chk_div_locked: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_ce && state_r == uabd_pkg::UABD_MEASURE && wr_acc && req.paddr == uabd_pkg::OFS_DIV
     && !(tick && sub_r == 3'h7))
    |=> $stable(div_r))
    else $error("divider written while measuring");
endmodule

/* uabd_remote_tx.sv */
// remote serial transmitter model sending calibration bytes
`timescale 1ns/100ps
module uabd_remote_tx
#(
  parameter int BIT_CLKS = 336
)
(
  input wire logic i_sys_clk,
  output logic o_line
);
  initial
  begin
    o_line = 1'b1;
  end
  task automatic hold_bits(input int n);
    repeat (n * BIT_CLKS) @(posedge i_sys_clk);
  endtask
  // optional break: long low, short idle, then the byte
  task automatic send(input logic brk);
    logic [9:0] frame;
    frame = {1'b1, 8'h55, 1'b0};
    if (brk)
    begin
      o_line <= 1'b0;
      hold_bits(13);
      o_line <= 1'b1;
      hold_bits(2);
    end
    for (int i = 0; i < 10; i++)
    begin
      o_line <= frame[i];
      hold_bits(1);
    end
  endtask
endmodule

/* uart_auto_baud_detect_bench.sv */
// self-checking bench for auto-baud detect: apb tasks, expectation queue, frame runs
`timescale 1ns/100ps
module uart_auto_baud_detect_bench;
  localparam int BIT_CLKS = 336;
  localparam int LIMIT = 60000;
  localparam logic [9:0] PRE [4] = '{uabd_pkg::DIV_00, uabd_pkg::DIV_01, uabd_pkg::DIV_10,
    uabd_pkg::DIV_11};
  logic clk, rst, ce, psel, penable, pwrite, rx, pready, pslverr, hold_idle, tx_load;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] baud_div, seed;
  logic [32:0] expq [$];
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int tx_loads = 0;
  uabd_top uut
  (
    .i_sys_clk(clk),
    .i_reset(rst),
    .i_ce(ce),
    .i_psel(psel),
    .i_penable(penable),
    .i_pwrite(pwrite),
    .i_paddr(paddr),
    .i_pwdata(pwdata),
    .o_prdata(prdata),
    .o_pready(pready),
    .o_pslverr(pslverr),
    .i_rx(rx),
    .o_rx_hold_idle(hold_idle),
    .o_baud_div(baud_div),
    .o_tx_load(tx_load)
  );
  uabd_remote_tx #(.BIT_CLKS(BIT_CLKS)) tx
  (
    .i_sys_clk(clk),
    .o_line(rx)
  );
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("mismatches=%0d checks=%0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // one apb transfer; reads note {pslverr, prdata} expected
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
    begin
      expq.push_back(e);
    end
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // arm, send a frame, then check divisor, flags and arm bit
  task automatic measure(input logic [4:0] ctrl, input logic brk, input logic [15:0] expd);
    apb(1'b1, uabd_pkg::OFS_CTRL, {27'h0, ctrl}, 33'h0);
    apb(1'b0, uabd_pkg::OFS_DIV, 32'h0, 33'h0);
    apb(1'b1, uabd_pkg::OFS_TXHOLD, {24'h0, seed[7:0]}, 33'h0);
    fork
      tx.send(brk);
      begin
        repeat (1500) @(posedge clk);
        check({32'h0, hold_idle}, 33'h1);
        if (brk)
        begin
          ce <= 1'b0;
          repeat (20) @(posedge clk);
          check({32'h0, hold_idle}, 33'h1);
          ce <= 1'b1;
        end
      end
    join
    repeat (8) @(posedge clk);
    apb(1'b0, uabd_pkg::OFS_CTRL, 32'h0, {28'h0, ctrl & 5'h1e});
    apb(1'b0, uabd_pkg::OFS_STATUS, 32'h0, 33'h2);
    apb(1'b0, uabd_pkg::OFS_DIV, 32'h0, {17'h0, expd});
    check({17'h0, baud_div}, {17'h0, expd});
    check({32'h0, hold_idle}, 33'h0);
    apb(1'b0, uabd_pkg::OFS_RXHOLD, 32'h0, 33'h0);
    apb(1'b0, uabd_pkg::OFS_STATUS, 32'h0, 33'h0);
  endtask
  // read results compared in arrival order
  always @(posedge clk)
  begin
    if (pready === 1'b1 && pwrite === 1'b0)
    begin
      check({pslverr, prdata}, expq.size() > 0 ? expq.pop_front() : 33'hx);
    end
    if (tx_load === 1'b1)
    begin
      tx_loads++;
    end
    cycles++;
    if (cycles == LIMIT)
    begin
      err_count++;
      report_and_stop();
    end
  end
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ce = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    seed = lfsr(16'h0033);
    apb(1'b1, uabd_pkg::OFS_DIV, {16'h0, seed}, 33'h0);
    apb(1'b0, uabd_pkg::OFS_DIV, 32'h0, {17'h0, seed});
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      measure({1'b0, i[0], i[1], 2'b01}, 1'b0, 16'((8 * BIT_CLKS) / (8 * int'(PRE[i]))));
    end
    measure(5'h0f, 1'b1, 16'h000a);
    check(33'(tx_loads), 33'h0);
    apb(1'b1, uabd_pkg::OFS_TXHOLD, {24'h0, seed[7:0]}, 33'h0);
    repeat (2) @(posedge clk);
    check(33'(tx_loads), 33'h1);
    apb(1'b0, uabd_pkg::OFS_STATUS, 32'h0, 33'h8);
    repeat (200) @(posedge clk);
    for (int v = 1; v >= 0; v--)
    begin
      apb(1'b1, uabd_pkg::OFS_STATUS, 32'(v), 33'h0);
      apb(1'b0, uabd_pkg::OFS_STATUS, 32'h0, 33'(v));
    end
    // preloaded divider rolls over mid-frame: flag set, arm kept, count goes on
    apb(1'b1, uabd_pkg::OFS_CTRL, 32'h0d, 33'h0);
    apb(1'b1, uabd_pkg::OFS_DIV, 32'h0000_fffc, 33'h0);
    fork
      tx.send(1'b0);
      begin
        repeat (2300) @(posedge clk);
        apb(1'b1, uabd_pkg::OFS_DIV, 32'h0000_1234, 33'h0);
        apb(1'b0, uabd_pkg::OFS_CTRL, 32'h0, 33'h0d);
        apb(1'b0, uabd_pkg::OFS_STATUS, 32'h0, 33'h5);
      end
    join
    repeat (8) @(posedge clk);
    apb(1'b0, uabd_pkg::OFS_STATUS, 32'h0, 33'h3);
    apb(1'b0, uabd_pkg::OFS_DIV, 32'h0, 33'h0006);
    apb(1'b0, uabd_pkg::OFS_RXHOLD, 32'h0, 33'h0);
    apb(1'b1, uabd_pkg::OFS_STATUS, 32'h0, 33'h0);
    apb(1'b0, uabd_pkg::OFS_STATUS, 32'h0, 33'h0);
    apb(1'b1, uabd_pkg::OFS_CTRL, 32'h1d, 33'h0);
    tx.send(1'b0);
    apb(1'b0, uabd_pkg::OFS_CTRL, 32'h0, 33'h1d);
    apb(1'b1, uabd_pkg::OFS_CTRL, 32'h0, 33'h0);
    apb(1'b0, 8'h20, 32'h0, 33'h1_00000000);
    repeat (4) @(posedge clk);
    report_and_stop();
  end
endmodule
